// ==== bench/ccd_divider_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
module ccd_divider_bench;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic        din = 0;
  logic [1:0]  ph = 2'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, c2a, c2b, c3a, c3b;
  int          failures = 0;
  int          cmp_count = 0;
  int          p2, h2, r2, p3, h3, r3;
  always #4 pclk = ~pclk;
  // four pclk per input cycle: each level stays at the two pclk minimum
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    din <= ph[1];
  end
  ccd_divider dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dist_clk_in(din), .ch2_out_a(c2a), .ch2_out_b(c2b), .ch3_out_a(c3a), .ch3_out_b(c3b));
  ccd_load ld2 (.pclk(pclk), .presetn(presetn), .clk_in(c2a), .period(p2), .high(h2), .rise_at(r2));
  ccd_load ld3 (.pclk(pclk), .presetn(presetn), .clk_in(c3a), .period(p3), .high(h3), .rise_at(r3));
  ////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [8:0] i, logic [7:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [8:0] i, logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask
  task automatic rd(string what, logic [8:0] i, logic [31:0] exp, logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, i, 8'h00, r, e);
    check(what, r, exp);
    check(what, {31'h0, e}, {31'h0, ee});
  endtask
  // same setup on both channels, then a restart so both run from a known point
  task automatic cfg(logic [7:0] s1, logic [7:0] s2, logic [7:0] byp, logic [7:0] duty);
    for (int c = 0; c < 10; c += 5) begin
      wr(`CCD_IDX_CH2_S1 + 9'(c), s1);
      wr(`CCD_IDX_CH2_S2 + 9'(c), s2);
      wr(`CCD_IDX_CH2_BYPASS + 9'(c), byp);
      wr(`CCD_IDX_CH2_DUTY + 9'(c), duty);
    end
    wr(`CCD_IDX_SYNC, 8'h01);
  endtask
  task automatic run(string what, int per, int hi);
    repeat (3 * per + 40) @(posedge pclk);
    check(what, p2, per);
    check(what, h2, hi);
    check(what, p3, per);
    check(what, h3, hi);
    $display("test %s done", what);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rd("stage1 reset", `CCD_IDX_CH2_S1, 32'h0000_0000, 1'b0);
    rd("duty reset", `CCD_IDX_CH3_DUTY, 32'h0000_0000, 1'b0);
    rd("out ctrl reset", `CCD_IDX_OUT_CTRL, 32'h0000_0000, 1'b0);
    wr(`CCD_IDX_CH3_S2, 8'ha5);
    rd("stage2 rw", `CCD_IDX_CH3_S2, 32'h0000_00a5, 1'b0);
    wr(`CCD_IDX_CH2_BYPASS, 8'hff);
    rd("bypass mask", `CCD_IDX_CH2_BYPASS, 32'h0000_0031, 1'b0);
    wr(`CCD_IDX_CH2_DUTY, 8'hff);
    rd("duty mask", `CCD_IDX_CH2_DUTY, 32'h0000_0001, 1'b0);
    rd("unmapped", 9'h000, 32'h0000_0000, 1'b1);
    rd("sync reads zero", `CCD_IDX_SYNC, 32'h0000_0000, 1'b0);
    $display("test regs done");
  endtask
  task automatic t_first;
    cfg(8'h21, 8'h00, 8'h20, 8'h01);
    run("first stage only", 20, 8);
  endtask
  task automatic t_cascade;
    cfg(8'h00, 8'h10, 8'h00, 8'h01);
    run("cascade", 24, 8);
  endtask
  task automatic t_max;
    cfg(8'hff, 8'hff, 8'h00, 8'h00);
    run("ratio 1024", 4096, 2048);
  endtask
  task automatic t_bypass;
    cfg(8'h00, 8'h00, 8'h30, 8'h01);
    run("both bypassed", 4, 2);
  endtask
  task automatic t_duty;
    cfg(8'h10, 8'h00, 8'h20, 8'h01);
    run("odd uncorrected", 12, 4);
    cfg(8'h10, 8'h00, 8'h20, 8'h00);
    run("odd corrected", 12, 6);
  endtask
  task automatic t_phase;
    int d;
    cfg(8'h77, 8'h00, 8'h20, 8'h00);
    wr(`CCD_IDX_CH2_PHASE, 8'h05);
    for (int k = 0; k < 2; k++) begin
      wr(`CCD_IDX_CH3_PHASE, k ? 8'h02 : 8'h00);
      wr(`CCD_IDX_CH3_BYPASS, k ? 8'h21 : 8'h20);
      wr(`CCD_IDX_SYNC, 8'h01);
      repeat (300) @(posedge pclk);
      // skew is taken modulo the 64 pclk period of both channels
      d = r2 - r3;
      if (d > 32) d -= 64;
      if (d < -32) d += 64;
      check("phase skew", d, k ? -20 : 20);
    end
    $display("test phase done");
  endtask
  task automatic t_out;
    cfg(8'h00, 8'h00, 8'h30, 8'h01);
    @(negedge pclk);
    check("b differential", c2a ^ c2b, 1);
    wr(`CCD_IDX_OUT_CTRL, 8'h05);
    repeat (3) @(posedge pclk);
    repeat (8) begin
      @(negedge pclk);
      check("b off", {c2b, c3b}, 0);
    end
    wr(`CCD_IDX_OUT_CTRL, 8'h0f);
    repeat (3) @(posedge pclk);
    repeat (8) begin
      @(negedge pclk);
      check("b on", {c2b, c3b}, {c2a, c3a});
    end
    $display("test outputs done");
  endtask
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_first();
    t_cascade();
    t_bypass();
    t_duty();
    t_phase();
    t_out();
    t_max();
    tally_and_finish();
  end
  // whole run is about 13700 pclk; over twice that means a hang
  initial begin
    repeat (32000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== bench/ccd_divider_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
////////////////////////////////////////
module ccd_divider_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dist_clk_in,
  input wire logic        ch2_out_a,
  input wire logic        ch2_out_b,
  input wire logic        ch3_out_a,
  input wire logic        ch3_out_b
);
  logic [3:0] oc;
  logic [1:0] by2;
  logic [1:0] by3;
  logic       wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !paddr[11];
  // private shadows, so a stuck register in the design cannot hide itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oc <= 4'h0;
    else if (wr && paddr[10:2] == `CCD_IDX_OUT_CTRL) oc <= pwdata[3:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      by2 <= 2'h0;
      by3 <= 2'h0;
    end else if (wr) begin
      if (paddr[10:2] == `CCD_IDX_CH2_BYPASS) by2 <= pwdata[5:4];
      if (paddr[10:2] == `CCD_IDX_CH3_BYPASS) by3 <= pwdata[5:4];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_bad_addr: assert property (psel && !penable && (paddr[11] || paddr[10:2] == 9'h000) |=> pslverr && prdata == 32'h0000_0000)
    else $error("no error on unmapped access");
  chk_ch2_single: assert property (oc[0] && $past(oc, 2) == oc && $past(presetn, 2) |-> ch2_out_b == (ch2_out_a & oc[1]))
    else $error("ch2 second output wrong");
  chk_ch3_single: assert property (oc[2] && $past(oc, 2) == oc && $past(presetn, 2) |-> ch3_out_b == (ch3_out_a & oc[3]))
    else $error("ch3 second output wrong");
  chk_ch2_diff: assert property (!oc[0] && $past(oc, 2) == oc && $past(presetn, 2) |-> ch2_out_b != ch2_out_a)
    else $error("ch2 pair not complementary");
  chk_ch3_diff: assert property (!oc[2] && $past(oc, 2) == oc && $past(presetn, 2) |-> ch3_out_b != ch3_out_a)
    else $error("ch3 pair not complementary");
  // four pclk from input pin to output pin when nothing divides: sampler, two stages, pin
  chk_ch2_bypass: assert property (by2 == 2'h3 && $past(by2, 4) == by2 && $past(presetn, 4) |-> ch2_out_a == $past(dist_clk_in, 4))
    else $error("ch2 bypass does not follow input");
  chk_ch3_bypass: assert property (by3 == 2'h3 && $past(by3, 4) == by3 && $past(presetn, 4) |-> ch3_out_a == $past(dist_clk_in, 4))
    else $error("ch3 bypass does not follow input");
endmodule
bind ccd_divider ccd_divider_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dist_clk_in(dist_clk_in), .ch2_out_a(ch2_out_a), .ch2_out_b(ch2_out_b),
  .ch3_out_a(ch3_out_a), .ch3_out_b(ch3_out_b));
`default_nettype wire

// ==== bench/ccd_load.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// clocked load: times the divided clock it receives, in pclk cycles
module ccd_load (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_in,
  output var  int   period,
  output var  int   high,
  output var  int   rise_at
);
  int   now;
  logic prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      now <= 0;
      prev <= 1'b0;
      period <= 0;
      high <= 0;
      rise_at <= 0;
    end else begin
      now <= now + 1;
      prev <= clk_in;
      if (clk_in && !prev) period <= now - rise_at;
      if (clk_in && !prev) rise_at <= now;
      if (!clk_in && prev) high <= now - rise_at;
    end
  end
endmodule
`default_nettype wire

// ==== logic/ccd_defines.svh ====
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// register indices; byte address is four times the index
`define CCD_IDX_CH2_S1      9'h199
`define CCD_IDX_CH2_PHASE   9'h19a
`define CCD_IDX_CH2_S2      9'h19b
`define CCD_IDX_CH2_BYPASS  9'h19c
`define CCD_IDX_CH2_DUTY    9'h19d
`define CCD_IDX_CH3_S1      9'h19e
`define CCD_IDX_CH3_PHASE   9'h19f
`define CCD_IDX_CH3_S2      9'h1a0
`define CCD_IDX_CH3_BYPASS  9'h1a1
`define CCD_IDX_CH3_DUTY    9'h1a2
`define CCD_IDX_OUT_CTRL    9'h1b0
`define CCD_IDX_SYNC        9'h1b1
`define CCD_IDX_STATUS      9'h1b2

// field positions
`define CCD_LOW_MSB         7
`define CCD_LOW_LSB         4
`define CCD_HIGH_MSB        3
`define CCD_HIGH_LSB        0
`define CCD_PO_MSB          3
`define CCD_PO_LSB          0
`define CCD_BYP_S1_BIT      4
`define CCD_BYP_S2_BIT      5
`define CCD_SH_BIT          0
`define CCD_DUTY_OFF_BIT    0
`define CCD_SYNC_BIT        0

// read masks for stored bytes
`define CCD_MASK_PHASE      8'h0f
`define CCD_MASK_BYPASS     8'h31
`define CCD_MASK_DUTY       8'h01
`define CCD_MASK_OUT_CTRL   8'h0f

// reset values
`define CCD_RST_COUNTS      8'h00
`define CCD_RST_PHASE       8'h00
`define CCD_RST_BYPASS      8'h00
`define CCD_RST_DUTY        8'h00
`define CCD_RST_OUT_CTRL    8'h00

// start-high weight in the combined phase offset
`define CCD_SH_WEIGHT       5'd16

`endif

// ==== logic/ccd_divider.sv ====
// Notes on behaviour
// - offset up to 15 delays the first output rise by that many input cycles
// - offset 16 or more delays by offset minus 16 plus low count plus one
// - per-channel offsets give skew in steps of one input clock period
// - each channel gives an output pair, differential after reset (b the complement of a), single-ended by control bit
// - two stages per channel, each 2 to 32, ratios multiply up to 1024
// - duty correction on by default in both stages, off by channel bit
// - low and high fields hold cycle count minus one
// - both stages bypassed divides by one
// - second bypassed gives first ratio; neither bypassed gives the product
// - correction off, first stage only: duty is first high over total
// - correction off, both stages: duty is second high over total
// - correction off, all bypassed, external clock: duty equals input duty
// - correction on with 50% input gives 50% in every permitted setup
// - low field 7:4, high 3:0, bypass bits 4 and 5, disable bit 0
// - combined offset is four-bit field plus start-high flag times 16
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// one divider stage, event driven on pclk
module ccd_stage
  import ccd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       in_level,
  input  wire logic       in_rise,
  input  wire logic       in_fall,
  input  wire logic [3:0] low_cycles,
  input  wire logic [3:0] high_cycles,
  input  wire logic       bypass,
  input  wire logic       duty_on,
  input  wire logic       restart,
  input  wire logic [4:0] start_delay,
  output logic            out_level,
  output logic            out_rise,
  output logic            out_fall,
  output logic            active
);

  ccd_phase_t st;
  ccd_phase_t next_st;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [4:0] wait_cnt;
  logic [4:0] next_wait;
  logic       fall_pend;
  logic       next_pend;
  logic       next_out;
  logic       odd_split;

  // odd ratio set as low = high + 1 gets its fall moved by half an input cycle
  assign odd_split = duty_on && ({1'b0, low_cycles} == ({1'b0, high_cycles} + 5'd1));
  assign active    = (st != CCD_WAIT);

  always_comb begin
    next_st   = st;
    next_cnt  = cnt;
    next_wait = wait_cnt;
    next_pend = fall_pend;
    next_out  = out_level;
    if (restart) begin
      next_st   = CCD_WAIT;
      next_cnt  = 4'h0;
      next_wait = start_delay;
      next_pend = 1'b0;
      next_out  = bypass ? in_level : 1'b0;
    end else if (bypass) begin
      // counter held idle, input passed straight on
      next_st   = CCD_WAIT;
      next_cnt  = 4'h0;
      next_wait = 5'd0;
      next_pend = 1'b0;
      next_out  = in_level;
    end else begin
      if (fall_pend && in_fall) begin
        next_out  = 1'b0;
        next_pend = 1'b0;
      end
      if (in_rise) begin
        case (st)
          CCD_WAIT: begin
            if (wait_cnt == 5'd0) begin
              next_st  = CCD_HIGH;
              next_out = 1'b1;
              next_cnt = 4'h0;
            end else begin
              next_wait = wait_cnt - 5'd1;
            end
          end
          CCD_HIGH: begin
            if (cnt == high_cycles) begin
              next_st  = CCD_LOW;
              next_cnt = 4'h0;
              if (odd_split) begin
                next_pend = 1'b1;
              end else begin
                next_out = 1'b0;
              end
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
          CCD_LOW: begin
            if (cnt == low_cycles) begin
              next_st  = CCD_HIGH;
              next_out = 1'b1;
              next_cnt = 4'h0;
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
          default: begin
            next_st  = CCD_WAIT;
            next_cnt = 4'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= CCD_WAIT;
      cnt       <= 4'h0;
      wait_cnt  <= 5'd0;
      fall_pend <= 1'b0;
    end else begin
      st        <= next_st;
      cnt       <= next_cnt;
      wait_cnt  <= next_wait;
      fall_pend <= next_pend;
    end
  end

  // edge marks line up with the level, so each cascaded stage adds one pclk of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level <= 1'b0;
      out_rise  <= 1'b0;
      out_fall  <= 1'b0;
    end else begin
      out_level <= next_out;
      out_rise  <= next_out & ~out_level;
      out_fall  <= ~next_out & out_level;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// top: register file on APB and two cascaded channels
module ccd_divider
  import ccd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dist_clk_in,
  output logic             ch2_out_a,
  output logic             ch2_out_b,
  output logic             ch3_out_a,
  output logic             ch3_out_b
);

  ccd_byte_t  s1_counts [2];
  ccd_byte_t  s2_counts [2];
  ccd_byte_t  phase_reg [2];
  ccd_byte_t  bypass_reg[2];
  ccd_byte_t  duty_reg  [2];
  ccd_byte_t  out_ctrl;
  logic       sync_pulse;

  logic [8:0] idx;
  logic       setup_ph;
  logic       wr_done;
  logic       hit;
  ccd_byte_t  rd_byte;

  logic       din_q;
  logic       din_prev;
  logic       din_rise;
  logic       din_fall;

  logic [4:0] delay    [2];
  logic [1:0] s1_level;
  logic [1:0] s1_rise;
  logic [1:0] s1_fall;
  logic [1:0] s1_act;
  logic [1:0] ch_level;
  logic [1:0] s2_act;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: setup cycle prepares the answer, access phase completes in one cycle

  assign idx      = paddr[10:2];
  assign setup_ph = psel && !penable;
  assign wr_done  = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `CCD_IDX_CH2_S1:     rd_byte = s1_counts[0];
      `CCD_IDX_CH2_PHASE:  rd_byte = phase_reg[0] & `CCD_MASK_PHASE;
      `CCD_IDX_CH2_S2:     rd_byte = s2_counts[0];
      `CCD_IDX_CH2_BYPASS: rd_byte = bypass_reg[0] & `CCD_MASK_BYPASS;
      `CCD_IDX_CH2_DUTY:   rd_byte = duty_reg[0] & `CCD_MASK_DUTY;
      `CCD_IDX_CH3_S1:     rd_byte = s1_counts[1];
      `CCD_IDX_CH3_PHASE:  rd_byte = phase_reg[1] & `CCD_MASK_PHASE;
      `CCD_IDX_CH3_S2:     rd_byte = s2_counts[1];
      `CCD_IDX_CH3_BYPASS: rd_byte = bypass_reg[1] & `CCD_MASK_BYPASS;
      `CCD_IDX_CH3_DUTY:   rd_byte = duty_reg[1] & `CCD_MASK_DUTY;
      `CCD_IDX_OUT_CTRL:   rd_byte = out_ctrl & `CCD_MASK_OUT_CTRL;
      `CCD_IDX_SYNC:       rd_byte = 8'h00;
      `CCD_IDX_STATUS:     rd_byte = {2'b00, s2_act, s1_act, ch_level};
      default:             hit = 1'b0;
    endcase
    if (paddr[11]) begin
      hit     = 1'b0;
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= (!pwrite && hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        s1_counts[i]  <= `CCD_RST_COUNTS;
        s2_counts[i]  <= `CCD_RST_COUNTS;
        phase_reg[i]  <= `CCD_RST_PHASE;
        bypass_reg[i] <= `CCD_RST_BYPASS;
        duty_reg[i]   <= `CCD_RST_DUTY;
      end
    end else if (wr_done) begin
      case (idx)
        `CCD_IDX_CH2_S1:     s1_counts[0]  <= pwdata[7:0];
        `CCD_IDX_CH2_PHASE:  phase_reg[0]  <= pwdata[7:0] & `CCD_MASK_PHASE;
        `CCD_IDX_CH2_S2:     s2_counts[0]  <= pwdata[7:0];
        `CCD_IDX_CH2_BYPASS: bypass_reg[0] <= pwdata[7:0] & `CCD_MASK_BYPASS;
        `CCD_IDX_CH2_DUTY:   duty_reg[0]   <= pwdata[7:0] & `CCD_MASK_DUTY;
        `CCD_IDX_CH3_S1:     s1_counts[1]  <= pwdata[7:0];
        `CCD_IDX_CH3_PHASE:  phase_reg[1]  <= pwdata[7:0] & `CCD_MASK_PHASE;
        `CCD_IDX_CH3_S2:     s2_counts[1]  <= pwdata[7:0];
        `CCD_IDX_CH3_BYPASS: bypass_reg[1] <= pwdata[7:0] & `CCD_MASK_BYPASS;
        `CCD_IDX_CH3_DUTY:   duty_reg[1]   <= pwdata[7:0] & `CCD_MASK_DUTY;
        default: begin
        end
      endcase
    end
  end

  // second output runs as the complement of a until software selects single-ended mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ctrl <= `CCD_RST_OUT_CTRL;
    end else if (wr_done && idx == `CCD_IDX_OUT_CTRL) begin
      out_ctrl <= pwdata[7:0] & `CCD_MASK_OUT_CTRL;
    end
  end

  // sync is a write-one pulse; new offsets reach the stages only through it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= wr_done && (idx == `CCD_IDX_SYNC) && pwdata[`CCD_SYNC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // distribution clock input, taken as synchronous to pclk

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_q    <= 1'b0;
      din_prev <= 1'b0;
    end else begin
      din_q    <= dist_clk_in;
      din_prev <= din_q;
    end
  end

  assign din_rise = din_q & ~din_prev;
  assign din_fall = ~din_q & din_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // cascaded channels

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [4:0] phi;
    logic [4:0] m_plus;

    // combined offset: four-bit field plus start-high weighted by 16
    assign phi    = {bypass_reg[c][`CCD_SH_BIT], phase_reg[c][`CCD_PO_MSB:`CCD_PO_LSB]};
    assign m_plus = {1'b0, s1_counts[c][`CCD_LOW_MSB:`CCD_LOW_LSB]} + 5'd1;
    // start-high form counts the low phase too
    assign delay[c] = phi[4] ? ((phi - `CCD_SH_WEIGHT) + m_plus) : phi;

    ccd_stage u_s1 (
      .pclk        (pclk),
      .presetn     (presetn),
      .in_level    (din_q),
      .in_rise     (din_rise),
      .in_fall     (din_fall),
      .low_cycles  (s1_counts[c][`CCD_LOW_MSB:`CCD_LOW_LSB]),
      .high_cycles (s1_counts[c][`CCD_HIGH_MSB:`CCD_HIGH_LSB]),
      .bypass      (bypass_reg[c][`CCD_BYP_S1_BIT]),
      .duty_on     (!duty_reg[c][`CCD_DUTY_OFF_BIT]),
      .restart     (sync_pulse),
      .start_delay (delay[c]),
      .out_level   (s1_level[c]),
      .out_rise    (s1_rise[c]),
      .out_fall    (s1_fall[c]),
      .active      (s1_act[c])
    );

    // second stage runs on first-stage edges, so ratios multiply
    ccd_stage u_s2 (
      .pclk        (pclk),
      .presetn     (presetn),
      .in_level    (s1_level[c]),
      .in_rise     (s1_rise[c]),
      .in_fall     (s1_fall[c]),
      .low_cycles  (s2_counts[c][`CCD_LOW_MSB:`CCD_LOW_LSB]),
      .high_cycles (s2_counts[c][`CCD_HIGH_MSB:`CCD_HIGH_LSB]),
      .bypass      (bypass_reg[c][`CCD_BYP_S2_BIT]),
      .duty_on     (!duty_reg[c][`CCD_DUTY_OFF_BIT]),
      .restart     (sync_pulse),
      .start_delay (5'd0),
      .out_level   (ch_level[c]),
      .out_rise    (),
      .out_fall    (),
      .active      (s2_act[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output pins: bit 0 of each pair selects single-ended mode, bit 1 enables b

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_out_a <= 1'b0;
      ch2_out_b <= 1'b0;
      ch3_out_a <= 1'b0;
      ch3_out_b <= 1'b0;
    end else begin
      ch2_out_a <= ch_level[0];
      ch3_out_a <= ch_level[1];
      // differential mode drives b as the complement of a
      ch2_out_b <= out_ctrl[0] ? (out_ctrl[1] & ch_level[0]) : ~ch_level[0];
      ch3_out_b <= out_ctrl[2] ? (out_ctrl[3] & ch_level[1]) : ~ch_level[1];
    end
  end

endmodule

`default_nettype wire

// ==== logic/ccd_pkg.sv ====
package ccd_pkg;

  typedef enum logic [1:0] {
    CCD_WAIT = 2'b00,
    CCD_HIGH = 2'b01,
    CCD_LOW  = 2'b10
  } ccd_phase_t;

  typedef logic [7:0] ccd_byte_t;

endpackage
